/* File: hw/erx_alarm_int.sv */
// E3 receive alarm and event interrupt logic with APB registers
// Assumes a framer upstream giving bit and byte strobes, frame marks and the
// maintenance byte, all synchronous to pclk
//
// Functional notes
// R1: all-ones alarm: <=7 zeros over 2 frames
// R2: alarm true sends far-end failure automatically
// R3: alarm false stops far-end failure automatically
// R4: trace message change raises interrupt when enabled
// R5: enable bit 6 at 0x13 gates trace
// R6: trace change sets flag bit 6, IRQ low
// R7: new trace stored in bytes 0x1C-0x2B
// R8: software reads all sixteen trace bytes
// R9: far-end failure change both ways interrupts
// R10: failure bit set declares far-end failure
// R11: failure bit clear clears far-end failure
// R12: enable bit 3 at 0x13 gates failure
// R13: failure change sets flag bit 3, IRQ low
// R14: bit 0 at 0x11 shows failure state
// R15: each block-error frame raises interrupt when enabled
// R16: enable bit 4 gates; flag bit 4
// R17: reading flags clears them; IRQ releases
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module erx_alarm_int
  import erx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic rx_frame_end,
  input wire logic rx_ma_valid,
  input wire logic [7:0] rx_maintenance_byte,
  input wire logic rx_trace_valid,
  input wire logic [7:0] rx_trace_byte,
  input wire logic rx_trace_start,
  input wire logic rx_trace_end,
  output logic tx_far_end_receive_failure,
  output logic irq_n
);

  // ----------------------------------------------------------------
  // Register address decode
  // ----------------------------------------------------------------
  // Register index of a byte address, or all ones when unaligned
  function automatic logic [9:0] reg_index(input logic [11:0] a);
    reg_index = (a[1:0] == 2'b00) ? a[11:2] : 10'h3FF;
  endfunction

  // True when the index falls in the trace byte window
  function automatic logic is_trace(input logic [9:0] idx);
    is_trace = (idx >= {2'b00, IDX_TRACE_FIRST}) &&
               (idx <= {2'b00, IDX_TRACE_LAST});
  endfunction

  logic [9:0] idx; // Decoded word index
  logic setup_rd; // Read setup cycle
  logic acc_rd; // Read access phase, wait state cycle included
  logic acc_wr; // Write access completes
  logic mapped; // Address hits a register
  assign idx = reg_index(paddr);
  assign mapped = (idx == {2'b00, IDX_CFG_STATE}) ||
                  (idx == {2'b00, IDX_INT_EN}) ||
                  (idx == {2'b00, IDX_INT_FLAGS}) || is_trace(idx);
  logic rd_wait_done; // First read access cycle has passed
  logic rd_load; // Read data is captured this cycle
  assign setup_rd = psel && !penable && !pwrite;
  assign acc_rd = psel && penable && !pwrite;
  assign acc_wr = psel && penable && pwrite && mapped;
  assign rd_load = acc_rd && !rd_wait_done;
  // Writes finish in one access cycle; reads take one wait state so
  // that the registered read data stands while pready is high
  assign pready = !rd_load;
  assign pslverr = psel && penable && !mapped;

  // Wait state marker, set by the first access cycle of a read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_wait_done <= 1'b0;
    else
      rd_wait_done <= rd_load;
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] int_en; // Interrupt enables
  logic algo_select; // Writable mode bit of the state register

  // Software writes to the enable register and the writable mode bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_en <= INT_EN_RESET;
      algo_select <= 1'b0;
    end
    else if (acc_wr)
    begin
      if (idx == {2'b00, IDX_INT_EN})
        int_en <= pwdata[7:0] & INT_EN_WMASK; // [R5] [R12] [R16]
      if (idx == {2'b00, IDX_CFG_STATE})
        algo_select <= pwdata[BIT_ALGO_SELECT];
    end
  end

  // ----------------------------------------------------------------
  // All-ones alarm detection
  // ----------------------------------------------------------------
  logic [ZCNT_W-1:0] zero_cnt; // Zeros seen in the current frame
  logic [ZCNT_W-1:0] next_zero_cnt; // Count including this bit
  logic [1:0] low_run; // Consecutive frames with few zeros
  logic [1:0] high_run; // Consecutive frames with many zeros
  logic all_ones_state; // Alarm condition
  logic frame_low; // This frame has few zeros
  logic frame_high; // This frame has many zeros

  assign next_zero_cnt = zero_cnt +
    ZCNT_W'(rx_bit_valid && !rx_bit);
  assign frame_low = next_zero_cnt <= ZCNT_W'(ALL_ONES_MAX_ZEROS);
  assign frame_high = next_zero_cnt >= ZCNT_W'(ALL_ONES_CLR_ZEROS);

  // Count zeros per frame, restart at frame end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      zero_cnt <= '0;
    else if (rx_frame_end)
      zero_cnt <= '0;
    else if (rx_bit_valid && !rx_bit && !(&zero_cnt))
      zero_cnt <= next_zero_cnt;
  end

  // Declare after two low frames, clear after two high frames
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_run <= 2'h0;
      high_run <= 2'h0;
      all_ones_state <= 1'b0;
    end
    else if (rx_frame_end)
    begin
      // Saturating runs of qualifying frames
      low_run <= frame_low ?
        ((low_run == 2'(ALL_ONES_FRAMES)) ? low_run : low_run + 2'h1) :
        2'h0;
      high_run <= frame_high ?
        ((high_run == 2'(ALL_ONES_FRAMES)) ? high_run : high_run + 2'h1) :
        2'h0;
      if (frame_low && low_run == 2'(ALL_ONES_FRAMES - 1))
        all_ones_state <= 1'b1; // [R1]
      else if (frame_high && high_run == 2'(ALL_ONES_FRAMES - 1))
        all_ones_state <= 1'b0; // [R1]
    end
  end

  // Far-end failure reply follows the alarm with no software help
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_far_end_receive_failure <= 1'b0;
    else
      tx_far_end_receive_failure <= all_ones_state; // [R2] [R3]
  end

  // ----------------------------------------------------------------
  // Maintenance byte: far-end failure and block error
  // ----------------------------------------------------------------
  logic far_fail_state; // Present far-end failure condition
  logic fail_change; // Failure state changes this cycle
  logic block_err_evt; // Block error frame received

  assign fail_change = rx_ma_valid &&
    (rx_maintenance_byte[MA_FAIL_BIT] != far_fail_state);
  assign block_err_evt = rx_ma_valid &&
    rx_maintenance_byte[MA_BLOCK_ERR_BIT];

  // Track the failure bit of each incoming maintenance byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      far_fail_state <= 1'b0;
    else if (fail_change)
      far_fail_state <= rx_maintenance_byte[MA_FAIL_BIT]; // [R10] [R11]
  end

  // ----------------------------------------------------------------
  // Trace message capture and compare
  // ----------------------------------------------------------------
  logic [7:0] shadow [TRACE_LEN]; // Message being received
  logic [7:0] stored [TRACE_LEN]; // Copy of last stored message
  logic [3:0] trace_pos; // Byte position in the message
  logic msg_differs; // Any byte differs so far
  logic trace_evt; // New message detected
  logic [3:0] copy_pos; // Copy pointer into the memory
  logic copy_busy; // Copy in progress
  logic [7:0] mem_rd; // Memory read data
  logic byte_diff; // Incoming byte differs from stored
  logic finish_diff; // Message complete and differs

  assign byte_diff = rx_trace_byte != stored[trace_pos];
  assign finish_diff = rx_trace_valid && rx_trace_end &&
    (msg_differs || byte_diff);
  assign trace_evt = finish_diff;

  // Collect bytes and note whether the message changed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trace_pos <= 4'h0;
      msg_differs <= 1'b0;
    end
    else if (rx_trace_valid)
    begin
      if (rx_trace_end)
      begin
        trace_pos <= 4'h0;
        msg_differs <= 1'b0;
      end
      else
      begin
        trace_pos <= rx_trace_start ? 4'h1 : trace_pos + 4'h1;
        msg_differs <= rx_trace_start ? (rx_trace_byte != stored[0]) :
          (msg_differs || byte_diff);
      end
    end
  end

  // Shadow bytes and reference copy, one generate slice per byte
  genvar g;
  generate
    for (g = 0; g < TRACE_LEN; g++)
    begin : g_trace
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          shadow[g] <= TRACE_RESET;
          stored[g] <= TRACE_RESET;
        end
        else
        begin
          if (rx_trace_valid && trace_pos == 4'(g) && !rx_trace_start)
            shadow[g] <= rx_trace_byte;
          else if (rx_trace_valid && rx_trace_start && g == 0)
            shadow[g] <= rx_trace_byte;
          // Reference takes the new message when it differs
          if (trace_evt)
            stored[g] <= (g == TRACE_LEN - 1) ? rx_trace_byte :
              shadow[g]; // [R4]
        end
      end
    end
  endgenerate

  // Copy the new message into the readable trace bytes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      copy_busy <= 1'b0;
      copy_pos <= 4'h0;
    end
    else if (trace_evt)
    begin
      copy_busy <= 1'b1;
      copy_pos <= 4'h0;
    end
    else if (copy_busy)
    begin
      copy_pos <= copy_pos + 4'h1;
      if (copy_pos == 4'(TRACE_LEN - 1))
        copy_busy <= 1'b0;
    end
  end

  // Readable byte store; read address taken in the setup cycle
  erx_trace_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(copy_busy), // [R7]
    .wr_addr(copy_pos),
    .wr_data(stored[copy_pos]),
    .rd_addr(4'(idx - {2'b00, IDX_TRACE_FIRST})),
    .rd_data(mem_rd)
  );

  // ----------------------------------------------------------------
  // Interrupt flags and request
  // ----------------------------------------------------------------
  logic [7:0] int_flags; // Sticky event flags
  logic [7:0] evt_vec; // Events this cycle
  logic flags_read; // Flag register read in its first access cycle

  assign evt_vec = (8'(trace_evt) << BIT_TRACE_INT) |
                   (8'(fail_change) << BIT_FAIL_INT) |
                   (8'(block_err_evt) << BIT_BLOCK_ERR_INT);
  assign flags_read = rd_load && idx == {2'b00, IDX_INT_FLAGS};

  // Set on enabled events; a read clears, but a new event still wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_flags <= FLAGS_RESET;
    else if (flags_read)
      int_flags <= evt_vec & int_en; // [R17] [R4] [R9] [R15]
    else
      int_flags <= int_flags | (evt_vec & int_en); // [R6] [R13] [R16]
  end

  // Request is low while any enabled flag is set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_n <= 1'b1;
    else
      irq_n <= ~|(next_flags() & int_en); // [R6] [R13] [R17]
  end

  // Value the flag register takes at the coming edge
  function automatic logic [7:0] next_flags();
    next_flags = flags_read ? (evt_vec & int_en) :
      (int_flags | (evt_vec & int_en));
  endfunction

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] state_reg; // Config and alarm state value
  assign state_reg = {algo_select, 3'b000, all_ones_state, 2'b00,
                      far_fail_state}; // [R14]

  // Registered read data, trace bytes come through the memory
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_rd)
      prdata <= 32'h0000_0000;
    else if (rd_load)
    begin
      if (idx == {2'b00, IDX_CFG_STATE})
        prdata <= {24'h000000, state_reg};
      else if (idx == {2'b00, IDX_INT_EN})
        prdata <= {24'h000000, int_en};
      else if (idx == {2'b00, IDX_INT_FLAGS})
        prdata <= {24'h000000, int_flags};
      else if (is_trace(idx))
        prdata <= {24'h000000, mem_rd}; // [R8]
      else
        prdata <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

/* File: hw/erx_pkg.sv */
// Package for the E3 receive alarm interrupt block
// Assumes a single pclk domain and an APB register interface
package erx_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses are four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CFG_STATE = 8'h11; // Config and alarm state
  localparam logic [7:0] IDX_INT_EN = 8'h13; // Interrupt enable
  localparam logic [7:0] IDX_INT_FLAGS = 8'h15; // Interrupt flags
  localparam logic [7:0] IDX_TRACE_FIRST = 8'h1C; // First trace byte
  localparam logic [7:0] IDX_TRACE_LAST = 8'h2B; // Last trace byte

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_FAR_FAIL_STATE = 0; // Far-end failure state
  localparam int BIT_ALL_ONES_STATE = 3; // All-ones alarm state
  localparam int BIT_ALGO_SELECT = 7; // Writable algorithm select
  localparam int BIT_FAIL_INT = 3; // Far-end failure interrupt
  localparam int BIT_BLOCK_ERR_INT = 4; // Block error interrupt
  localparam int BIT_TRACE_INT = 6; // Trace change interrupt
  localparam int MA_FAIL_BIT = 7; // Failure bit in maintenance byte
  localparam int MA_BLOCK_ERR_BIT = 6; // Block error bit in maint. byte

  // ----------------------------------------------------------------
  // Masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] INT_EN_WMASK = 8'h5F; // Writable enable bits
  localparam logic [7:0] INT_EN_RESET = 8'h00; // Enables after reset
  localparam logic [7:0] FLAGS_RESET = 8'h00; // Flags after reset
  localparam logic [7:0] TRACE_RESET = 8'h00; // Trace bytes after reset

  // ----------------------------------------------------------------
  // Alarm detection thresholds
  // ----------------------------------------------------------------
  localparam int ALL_ONES_MAX_ZEROS = 7; // Zeros at or under: alarm frame
  localparam int ALL_ONES_CLR_ZEROS = 8; // Zeros at or over: clean frame
  localparam int ALL_ONES_FRAMES = 2; // Consecutive frames needed
  localparam int TRACE_LEN = 16; // Trace message length in bytes
  localparam int ZCNT_W = 12; // Width of zero counter

endpackage

/* File: hw/erx_trace_mem.sv */
// Sixteen-byte store for the received trace message
// Assumes one writer port and one registered read port, same clock
`timescale 1ns/10ps
`default_nettype none
module erx_trace_mem
  import erx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [3:0] rd_addr,
  output logic [7:0] rd_data
);

  // Byte storage
  logic [7:0] mem [TRACE_LEN];

  // ----------------------------------------------------------------
  // Write and registered read
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < TRACE_LEN; i++)
        mem[i] <= TRACE_RESET;
      rd_data <= TRACE_RESET;
    end
    else
    begin
      if (wr_en)
        mem[wr_addr] <= wr_data;
      rd_data <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire

/* File: tb/e3_rx_alarm_interrupt_logic_tb.sv */
// Bench for the E3 receive alarm interrupt block
// Assumes the host model and checker files are compiled first
`timescale 1ns/10ps
`default_nettype none
module e3_rx_alarm_interrupt_logic_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic bv, bt, fe, mv, tv, ts, te, tx, irq_n;
  logic [7:0] mbyte, tbyte;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  erx_alarm_int erx_alarm_int_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_bit_valid(bv), .rx_bit(bt), .rx_frame_end(fe), .rx_ma_valid(mv),
    .rx_maintenance_byte(mbyte), .rx_trace_valid(tv),
    .rx_trace_byte(tbyte), .rx_trace_start(ts), .rx_trace_end(te),
    .tx_far_end_receive_failure(tx), .irq_n(irq_n));
  erx_host_model erx_host_model_inst (.pclk(pclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register access helpers
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    erx_host_model_inst.xfer(1'b0, a, 32'h0, q, e);
    chk({e, q[30:0]}, exp);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    erx_host_model_inst.xfer(1'b1, a, {24'h0, d}, q, e);
  endtask
  // Request pin and failure reply, sampled away from the edge
  task automatic pins(input logic ei, input logic et);
    repeat (2) @(negedge pclk);
    chk({30'h0, irq_n, tx}, {30'h0, ei, et});
  endtask
  // Stream drivers
  task automatic send_ma(input logic [7:0] b);
    @(posedge pclk);
    mv <= 1'b1;
    mbyte <= b;
    @(posedge pclk);
    mv <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic send_frame(input int z);
    for (int i = 0; i < 32; i++)
    begin
      @(posedge pclk);
      bv <= 1'b1;
      bt <= (i >= z);
      fe <= (i == 31);
    end
    @(posedge pclk);
    bv <= 1'b0;
    fe <= 1'b0;
  endtask
  task automatic send_trace(input logic [7:0] base);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      tv <= 1'b1;
      tbyte <= base + 8'(i);
      ts <= (i == 0);
      te <= (i == 15);
    end
    @(posedge pclk);
    tv <= 1'b0;
    te <= 1'b0;
    repeat (20) @(posedge pclk);
  endtask
  // Scenarios
  task automatic t_regs();
    rd(12'h044, 32'h0);
    rd(12'h054, 32'h0);
    rd(12'h0AC, 32'h0);
    wr(12'h04C, 8'hFF);
    rd(12'h04C, 32'h5F);
    wr(12'h04C, 8'h00);
    rd(12'h0FC, 32'h80000000);
    pins(1'b1, 1'b0);
    $display("t_regs done");
  endtask
  task automatic t_fail();
    wr(12'h04C, 8'h08);
    send_ma(8'h80);
    pins(1'b0, 1'b0);
    rd(12'h054, 32'h08);
    rd(12'h044, 32'h01);
    pins(1'b1, 1'b0);
    send_ma(8'h80);
    rd(12'h054, 32'h0);
    send_ma(8'h00);
    rd(12'h054, 32'h08);
    rd(12'h044, 32'h0);
    wr(12'h04C, 8'h00);
    send_ma(8'h80);
    pins(1'b1, 1'b0);
    rd(12'h054, 32'h0);
    send_ma(8'h00);
    $display("t_fail done");
  endtask
  task automatic t_block();
    wr(12'h04C, 8'h10);
    send_ma(8'h40);
    send_ma(8'hC0);
    pins(1'b0, 1'b0);
    rd(12'h054, 32'h10);
    rd(12'h054, 32'h0);
    wr(12'h04C, 8'h00);
    send_ma(8'h40);
    rd(12'h054, 32'h0);
    send_ma(8'h00);
    $display("t_block done");
  endtask
  task automatic t_trace();
    logic [7:0] m [16];
    wr(12'h04C, 8'h40);
    send_trace(8'hA0);
    pins(1'b0, 1'b0);
    rd(12'h054, 32'h40);
    erx_host_model_inst.read_trace(m);
    for (int i = 0; i < 16; i++)
      chk({24'h0, m[i]}, {24'h0, 8'hA0 + 8'(i)});
    send_trace(8'hA0);
    rd(12'h054, 32'h0);
    send_trace(8'hA1);
    rd(12'h054, 32'h40);
    wr(12'h04C, 8'h00);
    send_trace(8'hA2);
    rd(12'h054, 32'h0);
    $display("t_trace done");
  endtask
  task automatic t_alarm();
    send_frame(7);
    send_frame(8);
    pins(1'b1, 1'b0);
    send_frame(7);
    send_frame(7);
    pins(1'b1, 1'b1);
    rd(12'h044, 32'h08);
    send_frame(8);
    send_frame(7);
    pins(1'b1, 1'b1);
    send_frame(8);
    send_frame(8);
    pins(1'b1, 1'b0);
    rd(12'h044, 32'h0);
    $display("t_alarm done");
  endtask
  // Hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  initial
  begin
    {presetn, bv, bt, fe, mv, tv, ts, te} = 8'h00;
    mbyte = 8'h00;
    tbyte = 8'h00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_fail();
    t_block();
    t_trace();
    t_alarm();
    wrap_up();
  end
endmodule
bind erx_alarm_int erx_int_monitor erx_int_monitor_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .rx_frame_end(rx_frame_end), .rx_ma_valid(rx_ma_valid),
  .rx_maintenance_byte(rx_maintenance_byte),
  .rx_trace_valid(rx_trace_valid), .rx_trace_end(rx_trace_end),
  .tx_far_end_receive_failure(tx_far_end_receive_failure),
  .irq_n(irq_n));
`default_nettype wire

/* File: tb/erx_host_model.sv */
// Host processor model: APB master that services the block
// Assumes the block answers with pready, one pclk domain
`timescale 1ns/10ps
`default_nettype none
module erx_host_model
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Bus idle from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // One transfer; data and error are taken at the edge with pready high
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Service of a trace change fetches all sixteen bytes
  task automatic read_trace(output logic [7:0] m [16]);
    logic [31:0] q;
    logic e;
    for (int i = 0; i < 16; i++)
    begin
      xfer(1'b0, 12'h070 + 12'(4 * i), 32'h0, q, e);
      m[i] = q[7:0];
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/erx_int_monitor.sv */
// Port checker for the E3 receive alarm interrupt block
// Assumes one pclk domain and a bind from the bench top file
`timescale 1ns/10ps
`default_nettype none
module erx_int_monitor
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic rx_frame_end,
  input wire logic rx_ma_valid,
  input wire logic [7:0] rx_maintenance_byte,
  input wire logic rx_trace_valid,
  input wire logic rx_trace_end,
  input wire logic tx_far_end_receive_failure,
  input wire logic irq_n
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic [7:0] en; // Shadow of the enable register
  logic fstate; // Shadow of the far-end failure state
  logic [3:0] ev_age; // Cycles since a possible interrupt cause
  logic [3:0] svc_age; // Cycles since software serviced flags
  logic acc; // Access phase of a transfer
  logic cause; // Something that may raise the request
  logic [7:0] mb; // Short alias of the maintenance byte
  assign acc = psel && penable;
  assign mb = rx_maintenance_byte;
  assign cause = (rx_ma_valid && ((en[4] && mb[6]) ||
    (en[3] && mb[7] != fstate))) || (rx_trace_valid && rx_trace_end &&
    en[6]) || (acc && pwrite && paddr == 12'h04C);
  // Enable shadow and failure state follow the bus and the stream
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      en <= 8'h00;
    else if (acc && pwrite && paddr == 12'h04C)
      en <= pwdata[7:0];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      fstate <= 1'b0;
    else if (rx_ma_valid)
      fstate <= mb[7];
  // Age counters saturate so they never wrap to a false match
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ev_age <= 4'hF;
    else if (cause)
      ev_age <= 4'h0;
    else if (ev_age != 4'hF)
      ev_age <= ev_age + 4'h1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      svc_age <= 4'hF;
    else if (acc && (paddr == 12'h054 || (pwrite && paddr == 12'h04C)))
      svc_age <= 4'h0;
    else if (svc_age != 4'hF)
      svc_age <= svc_age + 4'h1;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_block_err_irq: assert property (
    rx_ma_valid && mb[6] && en[4] |-> ##[1:2] !irq_n)
    else $error("block error did not raise the request");
  a_fail_change_irq: assert property (
    rx_ma_valid && en[3] && mb[7] != fstate |-> ##[1:2] !irq_n)
    else $error("failure change did not raise the request");
  a_irq_cause: assert property (
    $fell(irq_n) |-> ev_age <= 4'h2)
    else $error("request fell without an enabled cause");
  a_irq_release: assert property (
    $rose(irq_n) |-> svc_age <= 4'h3)
    else $error("request released without service");
  a_read_release: assert property (
    $rose(acc) && !pwrite && paddr == 12'h054 |->
      ##2 (irq_n || ev_age <= 4'h1))
    else $error("request held after flags were read");
  a_reply_timing: assert property (
    $changed(tx_far_end_receive_failure) |->
      $past(rx_frame_end) || $past(rx_frame_end, 2))
    else $error("failure reply moved away from a frame end");
  a_state_read: assert property (
    $rose(acc) && !pwrite && paddr == 12'h044 |=>
      prdata[0] == $past(fstate))
    else $error("state bit does not show the failure state");
  a_alarm_read: assert property (
    $rose(acc) && !pwrite && paddr == 12'h044 |=>
      prdata[3] == tx_far_end_receive_failure)
    else $error("alarm bit and failure reply disagree");
endmodule
`default_nettype wire
